// file: operand_address_gen_consts.vh
/*
  Constants for the operand effective-address generator: addressing mode codes,
  address windows and register pair indices.
  Assumes it is included by its bare name from the design files.
*/
`ifndef OPERAND_ADDRESS_GEN_CONSTS_VH
`define OPERAND_ADDRESS_GEN_CONSTS_VH

// Addressing mode codes
`define MODE_DIRECT 3'h0
`define MODE_SHORT_DIRECT 3'h1
`define MODE_SPECIAL 3'h2
`define MODE_INDIRECT 3'h3
`define MODE_BASED 3'h4
`define MODE_STACK 3'h5
`define MODE_REGISTER 3'h6

// Address windows
`define SHORT_LOW_BASE 16'hfe00
`define SHORT_RAM_FIRST 16'hfe80
`define SHORT_RAM_LAST 16'hfeff
`define SHORT_SFR_FIRST 16'hff00
`define SHORT_SFR_LAST 16'hff1f
`define SPECIAL_PAGE 8'hff
`define SHORT_IMM_SFR_LAST 8'h1f

// Register pair indices
`define PAIR_ACCUMULATOR 2'h0
`define PAIR_COUNTER 2'h1
`define PAIR_INDIRECT 2'h2
`define PAIR_BASE 2'h3

`endif

// file: short_direct_map.v
/*
  Maps an 8-bit short direct immediate onto the 160-byte window and classifies it.
  Assumes a purely combinational use from the address generator.
*/
`timescale 1ns/10ps
`include "operand_address_gen_consts.vh"

module short_direct_map (
  input wire [7:0] imm,
  output wire [15:0] addr,
  output wire in_window,
  output wire is_ram
);

  // Upper byte FE or FF, bit 8 set for immediates 00H..7FH
  assign addr = {7'h7f, ~imm[7], imm};

  // Window check and RAM/register split
  assign in_window = imm[7] | (imm <= `SHORT_IMM_SFR_LAST);
  assign is_ram = imm[7];

endmodule // short_direct_map

// file: operand_address_gen.v
/*
  Operand effective-address generator: forms one registered 16-bit address and
  byte/word flag per operand access, and selects byte registers and pairs.
  The pulse outputs (address valid, register valid, address error) stand for
  exactly one cycle after the edge that takes a request; the data outputs
  hold their value until the next request.
  Assumes the decoder presents a request for one cycle with its fields, and the
  register file supplies the current pair values and stack pointer.
  Keeping the stack pointer inside internal RAM and word operands even is the
  caller's duty; the generator flags only the short direct faults it can see and the unused mode code.
  A word access uses the address as its low byte; the caller forms the +1.
*/
`timescale 1ns/10ps
`include "operand_address_gen_consts.vh"

module operand_address_gen (
  input wire mclk,
  input wire rst,
  input wire req,
  input wire [2:0] mode,
  input wire word,
  input wire [15:0] full_address_operand,
  input wire [7:0] imm8,
  input wire [2:0] reg_sel,
  input wire [1:0] register_pair_operand,
  input wire indirect_sel_base,
  input wire [15:0] indirect_pair,
  input wire [15:0] base_pair,
  input wire [15:0] stack_pointer,
  output wire addr_valid,
  output wire [15:0] eff_addr,
  output wire word_access,
  output wire to_ram,
  output wire to_sfr,
  output wire addr_error,
  output wire reg_valid,
  output wire [2:0] byte_reg_sel,
  output wire [1:0] pair_sel,
  output wire pair_mode
);

  // Short direct mapper results
  wire [15:0] short_addr;
  wire short_ok;
  wire short_ram;

  // Mode decode results before registering
  reg [15:0] addr_nxt;
  reg mem_nxt;
  reg err_nxt;

  // Short direct fault terms
  reg window_fault;
  reg odd_word;

  // Window classification of the selected address
  reg ram_nxt;
  reg sfr_nxt;

  // Registered results
  reg addr_valid_r;
  reg [15:0] eff_addr_r;
  reg word_access_r;
  reg to_ram_r;
  reg to_sfr_r;
  reg addr_error_r;
  reg reg_valid_r;
  reg [2:0] byte_reg_sel_r;
  reg [1:0] pair_sel_r;
  reg pair_mode_r;

  // Next values of the registered results
  reg addr_valid_nxt;
  reg [15:0] eff_addr_nxt;
  reg word_access_nxt;
  reg to_ram_nxt;
  reg to_sfr_nxt;
  reg addr_error_nxt;
  reg reg_valid_nxt;
  reg [2:0] byte_reg_sel_nxt;
  reg [1:0] pair_sel_nxt;
  reg pair_mode_nxt;

  // Short direct window mapping
  short_direct_map u_map (
    .imm(imm8),
    .addr(short_addr),
    .in_window(short_ok),
    .is_ram(short_ram)
  );

  // Faults that the short direct form can show; bytes 20H..7FH fall
  // outside the 160-byte window, and a word operand must sit on an even byte
  always @* begin
    window_fault = ~short_ok;
    odd_word = word & imm8[0];
  end

  // Effective address selection per mode; register mode and the
  // unused code raise no memory access
  always @* begin
    addr_nxt = 16'h0000;
    mem_nxt = 1'b1;
    err_nxt = 1'b0;
    case (mode)
      `MODE_DIRECT: addr_nxt = full_address_operand;
      `MODE_SHORT_DIRECT: begin
        addr_nxt = short_addr;
        err_nxt = window_fault | odd_word;
      end
      `MODE_SPECIAL: addr_nxt = {`SPECIAL_PAGE, imm8};
      `MODE_INDIRECT: addr_nxt = indirect_sel_base ? base_pair : indirect_pair;
      `MODE_BASED: addr_nxt = base_pair + {8'h00, imm8}; // Carry out dropped
      `MODE_STACK: addr_nxt = stack_pointer;
      `MODE_REGISTER: mem_nxt = 1'b0;
      default: begin
        mem_nxt = 1'b0;
        err_nxt = 1'b1;
      end
    endcase
  end

  // Internal RAM part and register page of the selected address
  always @* begin
    ram_nxt = (addr_nxt >= `SHORT_RAM_FIRST) & (addr_nxt <= `SHORT_RAM_LAST) & mem_nxt;
    sfr_nxt = (addr_nxt[15:8] == `SPECIAL_PAGE) & mem_nxt;
  end

  // Pulse outputs rise only after the edge that takes a request
  always @* begin
    addr_valid_nxt = req & mem_nxt;
    reg_valid_nxt = req & ~mem_nxt & ~err_nxt;
    addr_error_nxt = req & err_nxt;
  end

  // Memory side data loads on a request and holds between requests
  always @* begin
    eff_addr_nxt = eff_addr_r;
    word_access_nxt = word_access_r;
    to_ram_nxt = to_ram_r;
    to_sfr_nxt = to_sfr_r;
    if (req) begin
      eff_addr_nxt = addr_nxt;
      word_access_nxt = word;
      to_ram_nxt = ram_nxt;
      to_sfr_nxt = sfr_nxt;
    end
  end

  // Register side selection loads on a request and holds between requests
  always @* begin
    byte_reg_sel_nxt = byte_reg_sel_r;
    pair_sel_nxt = pair_sel_r;
    pair_mode_nxt = pair_mode_r;
    if (req) begin
      byte_reg_sel_nxt = reg_sel;
      pair_sel_nxt = register_pair_operand;
      pair_mode_nxt = word;
    end
  end

  // Pulse registers, cleared by reset
  always @(posedge mclk) begin
    if (rst) begin
      addr_valid_r <= 1'b0;
      reg_valid_r <= 1'b0;
      addr_error_r <= 1'b0;
    end else begin
      addr_valid_r <= addr_valid_nxt;
      reg_valid_r <= reg_valid_nxt;
      addr_error_r <= addr_error_nxt;
    end
  end

  // Memory side data registers, cleared by reset
  always @(posedge mclk) begin
    if (rst) begin
      eff_addr_r <= 16'h0000;
      word_access_r <= 1'b0;
      to_ram_r <= 1'b0;
      to_sfr_r <= 1'b0;
    end else begin
      eff_addr_r <= eff_addr_nxt;
      word_access_r <= word_access_nxt;
      to_ram_r <= to_ram_nxt;
      to_sfr_r <= to_sfr_nxt;
    end
  end

  // Register side selection registers, cleared by reset
  always @(posedge mclk) begin
    if (rst) begin
      byte_reg_sel_r <= 3'h0;
      pair_sel_r <= 2'h0;
      pair_mode_r <= 1'b0;
    end else begin
      byte_reg_sel_r <= byte_reg_sel_nxt;
      pair_sel_r <= pair_sel_nxt;
      pair_mode_r <= pair_mode_nxt;
    end
  end

  // Pulse outputs straight from their registers
  assign addr_valid = addr_valid_r;
  assign reg_valid = reg_valid_r;
  assign addr_error = addr_error_r;

  // Memory side outputs straight from their registers
  assign eff_addr = eff_addr_r;
  assign word_access = word_access_r;
  assign to_ram = to_ram_r;
  assign to_sfr = to_sfr_r;

  // Register side outputs straight from their registers
  assign byte_reg_sel = byte_reg_sel_r;
  assign pair_sel = pair_sel_r;
  assign pair_mode = pair_mode_r;

endmodule // operand_address_gen

// file: oag_regfile.sv
/* Register file model feeding the pair and stack pointer values.
   Assumes the bench loads one value per clock through wsel. */
`timescale 1ns/10ps
module oag_regfile (
  input wire mclk,
  input wire [1:0] wsel,
  input wire [15:0] wdata,
  output logic [15:0] indirect_pair = 16'h0000,
  output logic [15:0] base_pair = 16'h0000,
  output logic [15:0] stack_pointer = 16'hfefe // Starts inside internal RAM
);
  // Loads the selected pair or the stack pointer
  always @(posedge mclk) begin
    if (wsel == 2'h1) indirect_pair <= wdata;
    if (wsel == 2'h2) base_pair <= wdata;
    if (wsel == 2'h3) stack_pointer <= wdata;
  end
endmodule // oag_regfile

// file: operand_address_gen_assertions.sv
/* Checker for the operand address generator.
   Assumes it is bound to the top module by port name. */
`timescale 1ns/10ps
module oag_chk (
  input wire mclk, rst, req, word, indirect_sel_base, addr_valid,
  input wire word_access, to_ram, to_sfr, addr_error, reg_valid, pair_mode,
  input wire [2:0] mode, reg_sel, byte_reg_sel,
  input wire [1:0] register_pair_operand, pair_sel,
  input wire [7:0] imm8,
  input wire [15:0] full_address_operand, indirect_pair, base_pair, stack_pointer, eff_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  dir_addr_a: assert property (req && mode == 3'h0 |=> addr_valid && eff_addr == $past(full_address_operand))
    else $error("direct address wrong");
  short_map_a: assert property (req && mode == 3'h1 && (imm8[7] || imm8 < 8'h20) |=>
    eff_addr == {7'h7f, !$past(imm8[7]), $past(imm8)}) else $error("short address wrong");
  short_win_a: assert property (req && mode == 3'h1 && !imm8[7] && imm8[6:5] != 2'h0 |=> addr_error)
    else $error("window error missing");
  short_ram_a: assert property (req && mode == 3'h1 && imm8[7] |=> to_ram && !to_sfr)
    else $error("ram class wrong");
  sfr_page_a: assert property (req && mode == 3'h2 |=> eff_addr == {8'hff, $past(imm8)} && to_sfr)
    else $error("sfr address wrong");
  ind_pair_a: assert property (req && mode == 3'h3 |=>
    eff_addr == ($past(indirect_sel_base) ? $past(base_pair) : $past(indirect_pair))) else $error("indirect wrong");
  based_sum_a: assert property (req && mode == 3'h4 |=> eff_addr == $past(base_pair) + {8'h00, $past(imm8)})
    else $error("based sum wrong");
  stack_ptr_a: assert property (req && mode == 3'h5 |=> eff_addr == $past(stack_pointer))
    else $error("stack address wrong");
  reg_pick_a: assert property (req && mode == 3'h6 |=> reg_valid && byte_reg_sel == $past(reg_sel) &&
    pair_sel == $past(register_pair_operand)) else $error("register select wrong");
  word_flag_a: assert property (req && mode < 3'h6 |=> word_access == $past(word))
    else $error("word flag wrong");
  idle_out_a: assert property (!req |=> !addr_valid && !reg_valid)
    else $error("pulse without request");
  pair_flag_a: assert property (req && mode == 3'h6 |=> pair_mode == $past(word))
    else $error("pair flag wrong");
  bad_mode_a: assert property (req && mode == 3'h7 |=> addr_error && !addr_valid && !reg_valid)
    else $error("illegal mode not flagged");
  cover property (addr_valid && to_ram);
  cover property (reg_valid);
  cover property (addr_error);
endmodule // oag_chk
bind operand_address_gen oag_chk u_chk (.*);

// file: test_operand_address_gen.sv
/* Self-checking bench for the operand address generator.
   Assumes the register file model drives the pair inputs. */
`timescale 1ns/10ps
module test_operand_address_gen;
  logic mclk = 0, rst = 1, req = 0, word = 0, indirect_sel_base = 0;
  logic addr_valid, word_access, to_ram, to_sfr, addr_error, reg_valid, pair_mode;
  logic [2:0] mode = 0, reg_sel = 0, byte_reg_sel;
  logic [1:0] register_pair_operand = 0, pair_sel, wsel = 0;
  logic [7:0] imm8 = 0;
  logic [7:0] tbl [4] = '{8'h80, 8'hff, 8'h00, 8'h1f};
  logic [15:0] full_address_operand = 0, wdata = 0, indirect_pair, base_pair, stack_pointer, eff_addr;
  int err_total = 0, samples_checked = 0, cyc = 0;
  operand_address_gen DUT (.*);
  oag_regfile P (.*);
  // Clock and hang guard
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 2000) begin
    err_total++;
    report_and_stop;
  end
  task chk(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task op(input [2:0] m, input w, input [15:0] fa, input [7:0] i);
    mode = m; word = w; full_address_operand = fa; imm8 = i;
    reg_sel = fa[2:0]; register_pair_operand = fa[1:0]; req = 1;
    @(negedge mclk);
  endtask
  task setp(input [1:0] s, input [15:0] d);
    wsel = s; wdata = d;
    @(negedge mclk);
  endtask
  task fin(input string s);
    req = 0; wsel = 0;
    @(negedge mclk);
    $display("%s done", s);
  endtask
  task t_direct;
    op(3'h0, 1, 16'hfe80, 8'h00);
    chk("direct", eff_addr, 16'hfe80);
    chk("word", word_access, 16'h0001);
    chk("valid", addr_valid, 16'h0001);
    fin("direct");
  endtask
  task t_short;
    for (int k = 0; k < 4; k++) begin
      op(3'h1, 0, 16'h0000, tbl[k]);
      chk("short", eff_addr, {7'h7f, ~tbl[k][7], tbl[k]});
      chk("ram", to_ram, tbl[k][7]);
    end
    op(3'h1, 0, 16'h0000, 8'h20);
    chk("window", addr_error, 16'h0001);
    op(3'h2, 0, 16'h0000, 8'h40);
    chk("sfr", eff_addr, 16'hff40);
    chk("sfrcls", to_sfr, 16'h0001);
    fin("short");
  endtask
  task t_pairs;
    setp(2'h1, 16'h1234);
    setp(2'h2, 16'hffc0);
    setp(2'h3, 16'hfe20);
    op(3'h3, 1, 16'h0000, 8'h00);
    chk("indirect", eff_addr, 16'h1234);
    indirect_sel_base = 1;
    op(3'h3, 1, 16'h0000, 8'h00);
    chk("base", eff_addr, 16'hffc0);
    op(3'h4, 0, 16'h0000, 8'h50);
    chk("based", eff_addr, 16'h0010);
    op(3'h5, 1, 16'h0000, 8'h00);
    chk("stack", eff_addr, 16'hfe20);
    fin("pairs");
  endtask
  task t_reg;
    op(3'h6, 1, 16'h0005, 8'h00);
    chk("byte", byte_reg_sel, 16'h0005);
    chk("pair", pair_sel, 16'h0001);
    chk("nomem", addr_valid, 16'h0000);
    chk("regv", reg_valid, 16'h0001);
    chk("pmode", pair_mode, 16'h0001);
    fin("register");
  endtask
  task t_errors;
    op(3'h1, 1, 16'h0000, 8'h90); // Word operand on an even byte
    chk("even", addr_error, 16'h0000);
    chk("evenv", addr_valid, 16'h0001);
    op(3'h1, 1, 16'h0000, 8'h91);
    chk("odd", addr_error, 16'h0001);
    op(3'h7, 0, 16'h0000, 8'h00);
    chk("illegal", addr_error, 16'h0001);
    chk("nomem7", addr_valid, 16'h0000);
    chk("noreg7", reg_valid, 16'h0000);
    req = 0;
    @(negedge mclk);
    chk("pulse", addr_error, 16'h0000);
    fin("errors");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    rst = 0;
    t_direct;
    t_short;
    t_pairs;
    t_reg;
    t_errors;
    report_and_stop;
  end
endmodule // test_operand_address_gen
